/* File: bench/srp_link_chk.sv */
/*
 * Wire-level checker for the sensor link: address, selector and data answers.
 * Assumes it watches the interface joining both ends, on the one shared clock.
 */
`timescale 1ns/1ps
module srp_link_chk (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       dev_sda_oe,
	input  wire logic [2:0] address_strap_pins
);
	logic       scl_d, sda_d, rd, hit, wok;
	logic [3:0] bitcnt;
	logic [2:0] bytecnt;
	logic [7:0] shift, sel;
	wire        rise   = scl && !scl_d;
	wire        start  = scl && scl_d && sda_d && !sda;
	wire        ack    = rise && bitcnt == 4'h8;
	wire        sel_ok = shift inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h13, srp_pkg::SRP_CMD_COPY};

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
		end
	end

	// Bit and byte position within a frame
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bitcnt  <= 4'h0;
			bytecnt <= 3'h0;
			shift   <= 8'h00;
		end else if (start) begin
			bitcnt  <= 4'h0;
			bytecnt <= 3'h0;
		end else if (ack) begin
			bitcnt  <= 4'h0;
			bytecnt <= (bytecnt == 3'h7) ? bytecnt : bytecnt + 3'h1;
		end else if (rise) begin
			bitcnt <= bitcnt + 4'h1;
			shift  <= {shift[6:0], sda};
		end
	end

	// Direction, address match and selector as the sensor should hold them
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd  <= 1'b0;
			hit <= 1'b0;
			wok <= 1'b0;
			sel <= 8'h00;
		end else if (start) begin
			hit <= 1'b0;
			wok <= 1'b0;
		end else if (ack && bytecnt == 3'h0) begin
			rd  <= shift[0];
			hit <= !sda;
		end else if (ack && bytecnt == 3'h1 && !rd && hit) begin
			wok <= !sda && shift != srp_pkg::SRP_CMD_COPY;
			if (!sda && shift != srp_pkg::SRP_CMD_COPY)
				sel <= shift;
		end
	end

	a_addr_ack: assert property (ack && bytecnt == 3'h0 |->
		sda == (shift[7:1] != {srp_pkg::SRP_ADDR_FIXED, address_strap_pins}))
		else $error("address byte answered wrongly");
	a_quiet_miss: assert property (!hit && bytecnt != 3'h0 |-> !dev_sda_oe)
		else $error("sensor drives after a foreign address");
	a_sel_ack: assert property (ack && !rd && hit && bytecnt == 3'h1 |-> sda == !sel_ok)
		else $error("selector byte answered wrongly");
	a_temp_nack: assert property (ack && wok && bytecnt >= 3'h2 && sel == 8'h00 |-> sda)
		else $error("data byte to temperature register acknowledged");
	a_data_ack: assert property (ack && wok && bytecnt inside {3'h2, 3'h3} && sel != 8'h00 |-> !sda)
		else $error("data byte to writable register refused");
	a_read_release: assert property (ack && rd && hit && bytecnt != 3'h0 |-> !dev_sda_oe)
		else $error("sensor holds data line in host answer slot");
	a_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("sensor changes data line while clock high");
	a_start_free: assert property (start |-> !dev_sda_oe)
		else $error("sensor drives data line at start");
endmodule : srp_link_chk

/* File: bench/tb_sensor_register_pointer_access.sv */
/*
 * Bench: controller and sensor joined by the link interface, APB tasks, checker.
 * Assumes one 100 MHz clock and the fixed random seed below.
 */
`timescale 1ns/1ps
module tb_sensor_register_pointer_access;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        temp_load, measure_start, err;
	logic [7:0]  paddr, v;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] temp_data, act_cfg, act_low, act_high, d;
	logic [2:0]  strap;
	int          n_errors, n_checks, pulses;

	srp_link_if link ();
	srp_controller srp_controller_inst (.clk(clk), .reset(reset), .link(link), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	srp_sensor srp_sensor_inst (.clk(clk), .reset(reset), .link(link), .address_strap_pins(strap),
		.temp_data(temp_data), .temp_load(temp_load), .active_configuration(act_cfg),
		.active_low_limit(act_low), .active_high_limit(act_high), .measure_start(measure_start));
	srp_link_chk srp_link_chk_inst (.clk(clk), .reset(reset), .scl(link.scl), .sda(link.sda),
		.dev_sda_oe(link.dev_sda_oe), .address_strap_pins(strap));

	always #5 clk = ~clk;

	function automatic logic [31:0] ctrl_word(input logic rd_op, input logic [1:0] n);
		return {28'h0, n, rd_op, 1'b1};
	endfunction : ctrl_word

	// Upper byte alone leaves the lower byte as it was
	function automatic logic [31:0] exp_cfg(input logic [7:0] up, input logic [15:0] old);
		return {16'h0, up, old[7:0]};
	endfunction : exp_cfg

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Leaves the final status word in rd
	task automatic xfer(input logic [7:0] sel, input logic [31:0] ctrl, input logic [15:0] wd);
		apb(1'b1, srp_pkg::SRP_OFS_SEL, {24'h0, sel});
		apb(1'b1, srp_pkg::SRP_OFS_WDATA, {16'h0, wd});
		apb(1'b1, srp_pkg::SRP_OFS_CTRL, ctrl);
		rd = 32'h1;
		for (int i = 0; i < 20000 && rd[0] !== 1'b0; i++)
			apb(1'b0, srp_pkg::SRP_OFS_STATUS, 32'h0);
	endtask : xfer

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	initial begin
		#900000;
		n_errors++;
		final_report();
	end

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		{psel, penable, pwrite, temp_load} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		v = 8'($urandom(32'h7f3e639d));
		strap = 3'($urandom());
		temp_data = 16'($urandom());
		n_errors = 0;
		n_checks = 0;
		pulses = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (4) begin
			@(negedge clk);
			pulses += int'(measure_start);
		end
		check("measure_start", pulses, 1);
		check("active_cfg", {16'h0, act_cfg}, {16'h0, srp_pkg::SRP_NV_CFG_DEF});
		check("active_low", {16'h0, act_low}, {16'h0, srp_pkg::SRP_NV_LOW_DEF});
		check("active_high", {16'h0, act_high}, {16'h0, srp_pkg::SRP_NV_HIGH_DEF});
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped_err", {31'h0, err}, 32'h1);
		apb(1'b1, srp_pkg::SRP_OFS_STRAP, {29'h0, strap});
		apb(1'b0, srp_pkg::SRP_OFS_STRAP, 32'h0);
		check("strap_reg", rd, {29'h0, strap});
		// Read with no selector loaded since reset
		xfer(8'h00, ctrl_word(1'b1, 2'h1), 16'h0);
		check("read_status", rd & 32'h3, 32'h0);
		apb(1'b0, srp_pkg::SRP_OFS_RDATA, 32'h0);
		check("temp_upper", rd & 32'hff, 32'h0);
		apb(1'b1, srp_pkg::SRP_OFS_STRAP, {29'h0, strap ^ 3'h1});
		xfer(8'h01, ctrl_word(1'b0, 2'h0), 16'h0);
		check("foreign_addr", rd & 32'h3, 32'h2);
		apb(1'b1, srp_pkg::SRP_OFS_STRAP, {29'h0, strap});
		xfer(8'h21, ctrl_word(1'b0, 2'h0), 16'h0);
		check("bad_selector", rd & 32'h3, 32'h2);
		xfer(8'h01, ctrl_word(1'b0, 2'h1), {v, 8'h5a});
		check("cfg_write", rd & 32'h3, 32'h0);
		check("cfg_upper", {16'h0, act_cfg}, exp_cfg(v, srp_pkg::SRP_NV_CFG_DEF));
		check("low_kept", {16'h0, act_low}, {16'h0, srp_pkg::SRP_NV_LOW_DEF});
		xfer(8'h00, ctrl_word(1'b0, 2'h1), {v, v});
		check("temp_write", rd & 32'h3, 32'h2);
		check("idle_lines", {30'h0, link.scl, link.sda}, 32'h3);
		// New conversion, read with the selector left at temperature
		@(posedge clk);
		temp_load <= 1'b1;
		@(posedge clk);
		temp_load <= 1'b0;
		xfer(8'h00, ctrl_word(1'b1, 2'h2), 16'h0);
		apb(1'b0, srp_pkg::SRP_OFS_RDATA, 32'h0);
		check("temp_read", rd, {16'h0, temp_data});
		d = 16'($urandom());
		xfer(srp_pkg::SRP_SEL_NV_LOW, ctrl_word(1'b0, 2'h2), d);
		check("nv_write", rd & 32'h3, 32'h0);
		check("low_not_copied", {16'h0, act_low}, {16'h0, srp_pkg::SRP_NV_LOW_DEF});
		xfer(srp_pkg::SRP_SEL_NV_LOW, ctrl_word(1'b1, 2'h2), 16'h0);
		apb(1'b0, srp_pkg::SRP_OFS_RDATA, 32'h0);
		check("nv_read", rd, {16'h0, d});
		xfer(srp_pkg::SRP_CMD_COPY, ctrl_word(1'b0, 2'h0), 16'h0);
		check("copy_cmd", rd & 32'h3, 32'h0);
		check("low_copied", {16'h0, act_low}, {16'h0, d});
		// Second reset: selector and temperature back to defaults
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		apb(1'b1, srp_pkg::SRP_OFS_STRAP, {29'h0, strap});
		xfer(8'h00, ctrl_word(1'b1, 2'h2), 16'h0);
		apb(1'b0, srp_pkg::SRP_OFS_RDATA, 32'h0);
		check("temp_after_reset", rd, 32'h0);
		check("low_after_reset", {16'h0, act_low}, {16'h0, srp_pkg::SRP_NV_LOW_DEF});
		final_report();
	end
endmodule : tb_sensor_register_pointer_access

/* File: src/srp_controller.sv */
/*
 * Controller end: APB register set driving a two-wire master.
 * Assumes the sensor never stretches the clock line.
 */
`timescale 1ns/1ps
module srp_controller (
	input  wire logic        clk,
	input  wire logic        reset,
	srp_link_if.host         link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	typedef enum logic [1:0] {srp_h_idle, srp_h_start, srp_h_bit, srp_h_stop} srp_host_state_t;

	srp_host_state_t state;
	logic [1:0]      phase;
	logic [8:0]      tick_cnt;
	logic [3:0]      slot;
	logic [1:0]      byte_no;
	logic            abort;
	logic            busy;
	logic            nack;
	logic            rd;
	logic [1:0]      count;
	logic [7:0]      sel;
	logic [15:0]     wdata;
	logic [15:0]     rdata;
	logic [2:0]      strap;
	logic            scl_oe;
	logic            sda_oe;

	logic       tick;
	logic       wr_en;
	logic [1:0] last;
	logic       rx;
	logic [7:0] tx_byte;
	logic       go;

	assign tick  = tick_cnt == 9'(srp_pkg::SRP_QUARTER - 1);
	assign wr_en = psel && penable && pready && pwrite;
	assign go    = wr_en && (paddr == srp_pkg::SRP_OFS_CTRL) && pwdata[0] && !busy;
	assign last  = rd ? count : count + 2'h1;
	assign rx    = rd && (byte_no != 2'h0);

	always_comb begin
		unique case (byte_no)
			2'h0: tx_byte = {srp_pkg::SRP_ADDR_FIXED, strap, rd};
			2'h1: tx_byte = sel;
			2'h2: tx_byte = wdata[15:8];
			2'h3: tx_byte = wdata[7:0];
		endcase
	end

	assign link.host_scl_out = 1'b0;
	assign link.host_sda_out = 1'b0;
	assign link.host_scl_oe  = scl_oe;
	assign link.host_sda_oe  = sda_oe;

	// One wait state per access
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			unique case (paddr)
				srp_pkg::SRP_OFS_CTRL:   prdata <= {28'h0000000, count, rd, 1'b0};
				srp_pkg::SRP_OFS_SEL:    prdata <= {24'h000000, sel};
				srp_pkg::SRP_OFS_WDATA:  prdata <= {16'h0000, wdata};
				srp_pkg::SRP_OFS_RDATA:  prdata <= {16'h0000, rdata};
				srp_pkg::SRP_OFS_STATUS: prdata <= {30'h00000000, nack, busy};
				srp_pkg::SRP_OFS_STRAP:  prdata <= {29'h00000000, strap};
				default:                 pslverr <= 1'b1;
			endcase
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd    <= 1'b0;
			count <= 2'h0;
			sel   <= 8'h00;
			wdata <= 16'h0000;
			strap <= 3'h0;
		end else if (wr_en && !busy) begin
			unique case (paddr)
				srp_pkg::SRP_OFS_CTRL: begin
					rd    <= pwdata[1];
					count <= pwdata[3:2];
				end
				srp_pkg::SRP_OFS_SEL:   sel   <= pwdata[7:0];
				srp_pkg::SRP_OFS_WDATA: wdata <= pwdata[15:0];
				srp_pkg::SRP_OFS_STRAP: strap <= pwdata[2:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_cnt <= 9'h000;
		end else if (tick || state == srp_h_idle) begin
			tick_cnt <= 9'h000;
		end else begin
			tick_cnt <= tick_cnt + 9'h001;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state   <= srp_h_idle;
			phase   <= 2'h0;
			slot    <= 4'h0;
			byte_no <= 2'h0;
			abort   <= 1'b0;
			busy    <= 1'b0;
			nack    <= 1'b0;
			rdata   <= 16'h0000;
			scl_oe  <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (state == srp_h_idle) begin
			if (go) begin
				state   <= srp_h_start;
				phase   <= 2'h0;
				slot    <= 4'h0;
				byte_no <= 2'h0;
				abort   <= 1'b0;
				busy    <= 1'b1;
				nack    <= 1'b0;
				rdata   <= 16'h0000;
			end
		end else if (tick) begin
			phase <= phase + 2'h1;
			unique case (state)
				srp_h_start: begin
					if (phase == 2'h1) begin
						sda_oe <= 1'b1;
					end
					if (phase == 2'h3) begin
						scl_oe <= 1'b1;
						state  <= srp_h_bit;
					end
				end
				srp_h_bit: begin
					unique case (phase)
						2'h0: begin
							// Selector always resent first on writes
							if (slot == srp_pkg::SRP_ACK_SLOT) begin
								sda_oe <= rx && (byte_no != last);
							end else begin
								sda_oe <= !rx && !tx_byte[3'(7 - slot)];
							end
						end
						2'h1: scl_oe <= 1'b0;
						2'h2: begin
							if (slot != srp_pkg::SRP_ACK_SLOT && rx) begin
								rdata <= {rdata[14:0], link.sda};
							end else if (slot == srp_pkg::SRP_ACK_SLOT && !rx && link.sda) begin
								nack  <= 1'b1;
								abort <= 1'b1;
							end
						end
						2'h3: begin
							scl_oe <= 1'b1;
							if (slot == srp_pkg::SRP_ACK_SLOT) begin
								slot    <= 4'h0;
								byte_no <= byte_no + 2'h1;
								if (abort || byte_no == last) begin
									state <= srp_h_stop;
								end
							end else begin
								slot <= slot + 4'h1;
							end
						end
					endcase
				end
				srp_h_stop: begin
					unique case (phase)
						2'h0: sda_oe <= 1'b1;
						2'h1: scl_oe <= 1'b0;
						2'h2: sda_oe <= 1'b0;
						2'h3: begin
							busy  <= 1'b0;
							state <= srp_h_idle;
						end
					endcase
				end
				default: state <= srp_h_idle;
			endcase
		end
	end
endmodule : srp_controller

/* File: src/srp_link_if.sv */
/*
 * Two-wire open-drain link between controller and sensor.
 * Assumes each end drives low only while its enable is high.
 */
`timescale 1ns/1ps
interface srp_link_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Clock driven by the host alone, data a wired-AND of both ends; both pulled up when released
	assign scl = !(host_scl_oe && !host_scl_out);
	assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

	modport device (input scl, input sda, output dev_sda_out, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
		output host_sda_out, output host_sda_oe);
endinterface : srp_link_if

/* File: src/srp_pkg.sv */
/*
 * Shared constants for the sensor register link: register selectors,
 * storage indices, factory values, bus address and controller map.
 * Assumes one 100 MHz clock shared by both ends.
 */
// Functional notes
// - Reset copies stored settings into active ones
// - Active and stored registers written independently
// - Outputs expose only active register contents
// - Controller may issue copy command after updates
// - Selector values pick one of seven registers
// - Reads reuse last loaded selector
// - First write byte is always the selector
// - Upper selector bits zero except commands
// - Unknown selector byte is NACKed, selector kept
// - Address byte 1001 plus strap field, write
// - Selector resets to temperature register
// - One measurement requested right after reset
// - Config usable with upper byte only
// - Selector is write-only, never read back
// - Temperature register resets to zero
// - Read sends upper, lower; ACK restarts upper
// - Data bytes to temperature register NACKed
package srp_pkg;
	localparam logic [7:0]  SRP_SEL_TEMP    = 8'h00;
	localparam logic [7:0]  SRP_SEL_CFG     = 8'h01;
	localparam logic [7:0]  SRP_SEL_LOW     = 8'h02;
	localparam logic [7:0]  SRP_SEL_HIGH    = 8'h03;
	localparam logic [7:0]  SRP_SEL_NV_CFG  = 8'h11;
	localparam logic [7:0]  SRP_SEL_NV_LOW  = 8'h12;
	localparam logic [7:0]  SRP_SEL_NV_HIGH = 8'h13;
	localparam logic [7:0]  SRP_CMD_COPY    = 8'ha0;
	localparam logic [2:0]  SRP_IDX_TEMP    = 3'h0;
	localparam logic [2:0]  SRP_IDX_CFG     = 3'h1;
	localparam logic [2:0]  SRP_IDX_HIGH    = 3'h3;
	localparam logic [2:0]  SRP_IDX_NV_OFS  = 3'h3;
	localparam int          SRP_NUM_REGS    = 7;
	localparam logic [15:0] SRP_NV_CFG_DEF  = 16'h0000;
	localparam logic [15:0] SRP_NV_LOW_DEF  = 16'h4b00;
	localparam logic [15:0] SRP_NV_HIGH_DEF = 16'h5000;
	localparam logic [3:0]  SRP_ADDR_FIXED  = 4'h9;
	localparam logic [2:0]  SRP_LAST_BIT    = 3'h7;
	localparam logic [3:0]  SRP_ACK_SLOT    = 4'h8;
	localparam int          SRP_CLK_NS      = 10;
	localparam int          SRP_SCL_NS      = 2500;
	localparam int          SRP_QUARTER     = SRP_SCL_NS / SRP_CLK_NS / 4;
	localparam logic [7:0]  SRP_OFS_CTRL    = 8'h00;
	localparam logic [7:0]  SRP_OFS_SEL     = 8'h04;
	localparam logic [7:0]  SRP_OFS_WDATA   = 8'h08;
	localparam logic [7:0]  SRP_OFS_RDATA   = 8'h0c;
	localparam logic [7:0]  SRP_OFS_STATUS  = 8'h10;
	localparam logic [7:0]  SRP_OFS_STRAP   = 8'h14;

	function automatic logic srp_sel_valid(input logic [7:0] sel);
		srp_sel_valid = (sel == SRP_SEL_TEMP) || (sel == SRP_SEL_CFG) ||
			(sel == SRP_SEL_LOW) || (sel == SRP_SEL_HIGH) || (sel == SRP_SEL_NV_CFG) ||
			(sel == SRP_SEL_NV_LOW) || (sel == SRP_SEL_NV_HIGH);
	endfunction : srp_sel_valid

	function automatic logic [2:0] srp_sel_index(input logic [7:0] sel);
		logic [2:0] low;
		low = sel[2:0];
		srp_sel_index = sel[4] ? low + SRP_IDX_NV_OFS : low;
	endfunction : srp_sel_index
endpackage : srp_pkg

/* File: src/srp_sensor.sv */
/*
 * Sensor end: serial slave, selector and seven data registers.
 * Assumes link pins synchronous to clk and a controller without stretching.
 */
`timescale 1ns/1ps
module srp_sensor (
	input  wire logic        clk,
	input  wire logic        reset,
	srp_link_if.device       link,
	input  wire logic [2:0]  address_strap_pins,
	input  wire logic [15:0] temp_data,
	input  wire logic        temp_load,
	output logic [15:0]      active_configuration,
	output logic [15:0]      active_low_limit,
	output logic [15:0]      active_high_limit,
	output logic             measure_start
);
	typedef enum logic [2:0] {
		srp_idle, srp_addr, srp_ack_addr, srp_wr, srp_ack_wr, srp_rd, srp_ack_rd
	} srp_dev_state_t;

	srp_dev_state_t state;
	logic           scl_q;
	logic           sda_q;
	logic [2:0]     bit_cnt;
	logic [7:0]     shift;
	logic [7:0]     tx;
	logic           sda_oe;
	logic           ack_now;
	logic           ack_phase;
	logic           rd_mode;
	logic           hi_next;
	logic [1:0]     wr_idx;
	logic [7:0]     register_selector;
	logic           sel_fresh;
	logic [15:0]    data_reg [srp_pkg::SRP_NUM_REGS];
	logic           loaded;
	logic           temp_pend;
	logic [15:0]    temp_hold;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic [7:0] next_shift;
	logic       byte_in;
	logic       wr_ack;
	logic       sel_take;
	logic       copy_take;
	logic       data_take;
	logic [2:0] sel_idx;
	logic [7:0] rd_byte;
	logic       reading;

	assign scl_rise   = link.scl && !scl_q;
	assign scl_fall   = !link.scl && scl_q;
	assign start_cond = link.scl && scl_q && sda_q && !link.sda;
	assign stop_cond  = link.scl && scl_q && !sda_q && link.sda;
	assign next_shift = {shift[6:0], link.sda};
	assign byte_in    = (state == srp_wr) && scl_rise && (bit_cnt == srp_pkg::SRP_LAST_BIT);
	assign sel_idx    = srp_pkg::srp_sel_index(register_selector);
	// Upper byte first, then lower; repeated ACK wraps to upper
	assign rd_byte    = hi_next ? data_reg[sel_idx][15:8] : data_reg[sel_idx][7:0];
	assign reading    = (state == srp_rd) || (state == srp_ack_rd);

	always_comb begin
		if (wr_idx == 2'h0) begin
			// Selector byte or command; anything else refused
			wr_ack = srp_pkg::srp_sel_valid(next_shift) || (next_shift == srp_pkg::SRP_CMD_COPY);
		end else begin
			// Temperature register refuses data; at most two bytes
			wr_ack = sel_fresh && (sel_idx != srp_pkg::SRP_IDX_TEMP) && (wr_idx != 2'h3);
		end
	end

	assign sel_take  = byte_in && (wr_idx == 2'h0) && srp_pkg::srp_sel_valid(next_shift);
	assign copy_take = byte_in && (wr_idx == 2'h0) && (next_shift == srp_pkg::SRP_CMD_COPY);
	assign data_take = byte_in && (wr_idx != 2'h0) && wr_ack;

	assign link.dev_sda_out = 1'b0;
	assign link.dev_sda_oe  = sda_oe;

	// Volatile copies only drive the sensing logic
	assign active_configuration = data_reg[srp_pkg::SRP_IDX_CFG];
	assign active_low_limit     = data_reg[srp_pkg::SRP_IDX_CFG + 3'h1];
	assign active_high_limit    = data_reg[srp_pkg::SRP_IDX_HIGH];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= link.scl;
			sda_q <= link.sda;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state     <= srp_idle;
			bit_cnt   <= 3'h0;
			shift     <= 8'h00;
			tx        <= 8'h00;
			sda_oe    <= 1'b0;
			ack_now   <= 1'b0;
			ack_phase <= 1'b0;
			rd_mode   <= 1'b0;
			hi_next   <= 1'b1;
			wr_idx    <= 2'h0;
		end else if (start_cond) begin
			state     <= srp_addr;
			bit_cnt   <= 3'h0;
			sda_oe    <= 1'b0;
			ack_phase <= 1'b0;
			wr_idx    <= 2'h0;
		end else if (stop_cond) begin
			state  <= srp_idle;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				srp_idle: begin
				end
				srp_addr: begin
					if (scl_rise) begin
						shift   <= next_shift;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == srp_pkg::SRP_LAST_BIT) begin
							// Fixed prefix plus strap field
							ack_now <= next_shift[7:1] == {srp_pkg::SRP_ADDR_FIXED, address_strap_pins};
							rd_mode <= next_shift[0];
							hi_next <= 1'b1;
							state   <= srp_ack_addr;
						end
					end
				end
				srp_ack_addr: begin
					if (scl_fall) begin
						if (!ack_phase) begin
							sda_oe    <= ack_now;
							ack_phase <= 1'b1;
						end else begin
							ack_phase <= 1'b0;
							bit_cnt   <= 3'h0;
							if (!ack_now) begin
								sda_oe <= 1'b0;
								state  <= srp_idle;
							end else if (rd_mode) begin
								sda_oe  <= !rd_byte[7];
								tx      <= {rd_byte[6:0], 1'b0};
								hi_next <= !hi_next;
								state   <= srp_rd;
							end else begin
								sda_oe <= 1'b0;
								state  <= srp_wr;
							end
						end
					end
				end
				srp_wr: begin
					if (scl_rise) begin
						shift   <= next_shift;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == srp_pkg::SRP_LAST_BIT) begin
							ack_now <= wr_ack;
							if (wr_idx != 2'h3) begin
								wr_idx <= wr_idx + 2'h1;
							end
							state <= srp_ack_wr;
						end
					end
				end
				srp_ack_wr: begin
					if (scl_fall) begin
						if (!ack_phase) begin
							sda_oe    <= ack_now;
							ack_phase <= 1'b1;
						end else begin
							ack_phase <= 1'b0;
							sda_oe    <= 1'b0;
							bit_cnt   <= 3'h0;
							state     <= ack_now ? srp_wr : srp_idle;
						end
					end
				end
				srp_rd: begin
					if (scl_fall) begin
						if (bit_cnt == srp_pkg::SRP_LAST_BIT) begin
							sda_oe <= 1'b0;
							state  <= srp_ack_rd;
						end else begin
							sda_oe  <= !tx[7];
							tx      <= {tx[6:0], 1'b0};
							bit_cnt <= bit_cnt + 3'h1;
						end
					end
				end
				srp_ack_rd: begin
					if (scl_rise) begin
						ack_now <= !link.sda;
					end else if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (ack_now) begin
							sda_oe  <= !rd_byte[7];
							tx      <= {rd_byte[6:0], 1'b0};
							hi_next <= !hi_next;
							state   <= srp_rd;
						end else begin
							state <= srp_idle;
						end
					end
				end
			endcase
		end
	end

	// Selector: reset to temperature, kept until a valid byte
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			register_selector <= srp_pkg::SRP_SEL_TEMP;
			sel_fresh         <= 1'b0;
		end else begin
			if (start_cond) begin
				sel_fresh <= 1'b0;
			end else if (sel_take) begin
				sel_fresh <= 1'b1;
			end
			if (sel_take) begin
				register_selector <= next_shift;
			end
		end
	end

	// Conversion result parked while a read is under way
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			temp_pend <= 1'b0;
			temp_hold <= 16'h0000;
		end else if (temp_load) begin
			temp_pend <= 1'b1;
			temp_hold <= temp_data;
		end else if (!reading) begin
			temp_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			loaded        <= 1'b0;
			measure_start <= 1'b0;
		end else begin
			loaded        <= 1'b1;
			measure_start <= !loaded;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			data_reg[srp_pkg::SRP_IDX_TEMP] <= 16'h0000;
			data_reg[1] <= srp_pkg::SRP_NV_CFG_DEF;
			data_reg[2] <= srp_pkg::SRP_NV_LOW_DEF;
			data_reg[3] <= srp_pkg::SRP_NV_HIGH_DEF;
			data_reg[4] <= srp_pkg::SRP_NV_CFG_DEF;
			data_reg[5] <= srp_pkg::SRP_NV_LOW_DEF;
			data_reg[6] <= srp_pkg::SRP_NV_HIGH_DEF;
		end else begin
			if (temp_pend && !reading) begin
				data_reg[srp_pkg::SRP_IDX_TEMP] <= temp_hold;
			end
			if (!loaded || copy_take) begin
				for (int i = 1; i <= 3; i++) begin
					data_reg[i] <= data_reg[i + 3];
				end
			end else if (data_take) begin
				// Each register written alone; upper byte alone is kept
				if (wr_idx == 2'h1) begin
					data_reg[sel_idx][15:8] <= next_shift;
				end else begin
					data_reg[sel_idx][7:0] <= next_shift;
				end
			end
		end
	end
endmodule : srp_sensor
